// ===== ptr_pkg.sv
package ptr_pkg;

	// ==========================================================
	// Register map of the APB window (word aligned byte addresses).
	localparam logic [7:0] OFF_DATA_PAGE = 8'h00;
	localparam logic [7:0] OFF_STACK_TOP = 8'h04;
	localparam logic [7:0] OFF_INSTR_PTR = 8'h08;
	localparam logic [7:0] OFF_SAVED_RET = 8'h0c;
	localparam logic [7:0] OFF_EXEC_ST   = 8'h10;
	localparam logic [7:0] OFF_DEC_ST    = 8'h14;
	localparam logic [7:0] OFF_IRQ_PEND  = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
	localparam logic [7:0] OFF_DBG_MASK  = 8'h20;
	localparam logic [7:0] OFF_MODE      = 8'h24;
	localparam logic [7:0] OFF_AUX_BASE  = 8'h40;

	// ==========================================================
	// Widths and reset values.
	localparam int         PAGE_OFS_W     = 6;
	localparam int         LEGACY_OFS_W   = 7;
	localparam int         DADDR_W        = 22;
	localparam int         BUS_ADDR_W     = 32;
	localparam int         STACK_ZERO_W   = 6;
	localparam logic [15:0] STACK_RST     = 16'h0400;
	localparam logic [21:0] INSTR_PTR_RST = 22'h3fffc0;
	localparam logic [15:0] DEC_ST_RST    = 16'h080b;
	localparam int         MODE_LEGACY_BIT = 0;

	// Pointer operation requested by the core sequencer.
	typedef enum logic [2:0] {
		OP_NONE, OP_PUSH32, OP_POP32, OP_ADJ,
		OP_LCALL, OP_LRET
	} ptr_op_e;

	// Memory access issued on behalf of a stack sequence.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [21:0] addr;
		logic [15:0] wdata;
	} mem_req_s;

endpackage : ptr_pkg

// ===== aux_pointer_slot.sv
`timescale 1ns/10ps

// One 32-bit auxiliary pointer with a separately writable low view.
module aux_pointer_slot (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        wr_full,
	input  wire logic        wr_low,
	input  wire logic        wr_low_keep,
	input  wire logic [31:0] wdata,
	output logic      [31:0] value
);

	// ==========================================================
	// Storage; a low-view write may or may not clear the high half.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			value <= 32'h0000_0000;
		end else if (wr_full) begin
			value <= wdata;
		end else if (wr_low) begin
			value[15:0] <= wdata[15:0];
			if (!wr_low_keep) begin
				value[31:16] <= 16'h0000;
			end
		end
	end

endmodule : aux_pointer_slot

// ===== cpu_pointer_registers.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps

// Behaviour
// - Direct addressing uses 64-word pages chosen by the 16-bit page pointer.
// - Page addressing reaches only the lowest 4M words, 65,536 pages.
// - Legacy mode: 7-bit offset, page pointer bit 0 ignored.
// - Stack pointer is 16 bits; its addresses have upper six bits zero.
// - Reset loads the stack pointer with 0400 hex.
// - Stack grows upward; pointer names the next free location.
// - 32-bit push writes low half first, high half at next address.
// - Stack pointer arithmetic wraps modulo 16 bits.
// - Stack pointer is never rounded to even or odd on saves.
// - Eight 32-bit auxiliary pointers, each with a 16-bit low view.
// - Upper aux halves have no own path; low writes may clear them.
// - Wide operations use 32 aux bits, 16-bit ones only the low half.
// - Auxiliary pointers may also address program memory.
// - The 22-bit instruction pointer tracks the second decode stage.
// - An instruction in second decode is never flushed by an interrupt.
// - Long call stores return in saved register, pushes old value by two stack writes.
// - Long return uses saved register, reloads it by two stack reads.
// - Other calls leave the saved-return register untouched.
// - Both status registers can be stored and loaded from memory.
// - Execute-stage status updates in execute, other in second decode.
// - An interrupt is serviced when pending and its mask bit is set.
module cpu_pointer_registers #(
	parameter int N_AUX = 8
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// APB slave.
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Core sequencer side.
	input  wire ptr_pkg::ptr_op_e       op,
	input  wire logic [15:0]            op_amount,
	input  wire logic                   op_sub,
	input  wire logic [21:0]            call_target,
	input  wire logic [31:0]            push_data,
	input  wire logic                   decode2_adv,
	input  wire logic [21:0]            decode2_addr,
	input  wire logic                   exec_st_we,
	input  wire logic [15:0]            exec_st_val,
	input  wire logic                   dec_st_we,
	input  wire logic [15:0]            dec_st_val,
	input  wire logic [15:0]            irq_hw_set,
	input  wire logic                   irq_ack,
	input  wire logic [3:0]             irq_ack_num,
	// Addressing.
	input  wire logic [6:0]             page_offset,
	output logic      [21:0]            page_addr,
	input  wire logic [2:0]             aux_sel,
	output logic      [31:0]            aux_pointer_regs,
	output logic      [15:0]            aux_pointer_low,
	output logic      [21:0]            aux_prog_addr,
	// Stack memory port; one 16-bit word per request, addresses never aligned.
	output ptr_pkg::mem_req_s           mem_req,
	input  wire logic                   mem_ack,
	input  wire logic [15:0]            mem_rdata,
	output logic                        seq_busy,
	output logic      [21:0]            return_addr,
	output logic                        return_valid,
	output logic      [ptr_pkg::BUS_ADDR_W-1:0] stack_addr,
	output logic      [21:0]            instr_pointer,
	output logic                        irq_take,
	output logic      [3:0]             irq_take_num
);
	import ptr_pkg::*;

	typedef enum {
		S_IDLE, S_PUSH_LO, S_PUSH_HI, S_POP_HI, S_POP_LO
	} seq_e;

	logic [15:0] data_page_pointer_r;
	logic [15:0] stack_top_pointer_r;
	logic [15:0] stack_top_pointer_nxt;
	logic [21:0] instr_pointer_r;
	logic [21:0] saved_return_pointer_r;
	logic [15:0] exec_stage_status_r;
	logic [15:0] decode_stage_status_r;
	logic [15:0] irq_pending_flags_r;
	logic [15:0] irq_mask_bits_r;
	logic [15:0] debug_irq_mask_r;
	logic [31:0] mode_r;
	seq_e        seq_r;
	logic [31:0] seq_data_r;
	logic        seq_is_ret_r;
	logic [15:0] pop_hi_r;
	logic        apb_wr;
	logic        apb_rd;
	logic [31:0] aux_val [N_AUX];
	logic [15:0] pend_mask;
	logic [15:0] irq_clr;
	logic [3:0]  irq_pick;

	// ==========================================================
	// APB decode; every access completes without wait states.
	assign pready  = 1'b1;
	assign apb_wr  = psel && penable && pwrite;
	assign apb_rd  = psel && !penable && !pwrite;

	// Error for unmapped addresses and misaligned offsets.
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			if (paddr[1:0] != 2'b00) begin
				pslverr = 1'b1;
			end else if (paddr > OFF_MODE && paddr < OFF_AUX_BASE) begin
				pslverr = 1'b1;
			end else if (paddr >= OFF_AUX_BASE + 8'(4 * N_AUX)) begin
				pslverr = 1'b1;
			end
		end
	end

	// ==========================================================
	// Page-based direct address.
	always_comb begin
		if (mode_r[MODE_LEGACY_BIT]) begin
			page_addr = {data_page_pointer_r[15:1],
				page_offset};
		end else begin
			page_addr = {data_page_pointer_r,
				page_offset[PAGE_OFS_W-1:0]};
		end
	end

	// Data page pointer register.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_page_pointer_r <= 16'h0000;
		end else if (apb_wr && paddr == OFF_DATA_PAGE) begin
			data_page_pointer_r <= pwdata[15:0];
		end
	end

	// Mode register; bit 0 selects the legacy 7-bit offset.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_r <= 32'h0000_0000;
		end else if (apb_wr && paddr == OFF_MODE) begin
			mode_r <= {31'h0000_0000, pwdata[MODE_LEGACY_BIT]};
		end
	end

	// ==========================================================
	// Stack pointer; addresses are zero-extended, never aligned.
	assign stack_addr = {{(BUS_ADDR_W-16){1'b0}},
		stack_top_pointer_r};

	// Next stack pointer; all sums wrap in 16 bits.
	always_comb begin
		stack_top_pointer_nxt = stack_top_pointer_r;
		if (seq_r == S_IDLE && op == OP_ADJ) begin
			if (op_sub) begin
				stack_top_pointer_nxt = stack_top_pointer_r
					- op_amount;
			end else begin
				stack_top_pointer_nxt = stack_top_pointer_r
					+ op_amount;
			end
		end else if (mem_ack && (seq_r == S_PUSH_LO
				|| seq_r == S_PUSH_HI)) begin
			stack_top_pointer_nxt = stack_top_pointer_r
				+ 16'h0001;
		end else if (mem_ack && (seq_r == S_POP_HI
				|| seq_r == S_POP_LO)) begin
			stack_top_pointer_nxt = stack_top_pointer_r - 16'h0001;
		end
	end

	// Stack pointer register; software writes rank below the sequencer.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stack_top_pointer_r <= STACK_RST;
		end else if (stack_top_pointer_nxt != stack_top_pointer_r) begin
			stack_top_pointer_r <= stack_top_pointer_nxt;
		end else if (apb_wr && paddr == OFF_STACK_TOP) begin
			stack_top_pointer_r <= pwdata[15:0];
		end
	end

	// ==========================================================
	// Push and pop sequencer, one 16-bit word per memory handshake.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seq_r        <= S_IDLE;
			seq_data_r   <= 32'h0000_0000;
			seq_is_ret_r <= 1'b0;
			pop_hi_r     <= 16'h0000;
		end else begin
			case (seq_r)
				S_IDLE: begin
					seq_is_ret_r <= (op == OP_LRET);
					if (op == OP_PUSH32) begin
						seq_data_r <= push_data;
						seq_r      <= S_PUSH_LO;
					end else if (op == OP_LCALL) begin
						seq_data_r <= {10'h000,
							saved_return_pointer_r};
						seq_r      <= S_PUSH_LO;
					end else if (op == OP_POP32 || op == OP_LRET) begin
						seq_r <= S_POP_HI;
					end
				end
				S_PUSH_LO: begin
					if (mem_ack) begin
						seq_r <= S_PUSH_HI;
					end
				end
				S_PUSH_HI: begin
					if (mem_ack) begin
						seq_r <= S_IDLE;
					end
				end
				S_POP_HI: begin
					if (mem_ack) begin
						pop_hi_r <= mem_rdata;
						seq_r    <= S_POP_LO;
					end
				end
				S_POP_LO: begin
					if (mem_ack) begin
						seq_data_r <= {pop_hi_r, mem_rdata};
						seq_r      <= S_IDLE;
					end
				end
				default: seq_r <= S_IDLE;
			endcase
		end
	end

	// Memory request; pops read the word just below the pointer.
	always_comb begin
		mem_req       = '0;
		mem_req.addr  = {6'h00, stack_top_pointer_r};
		mem_req.wdata = seq_data_r[15:0];
		case (seq_r)
			S_PUSH_LO: begin
				mem_req.valid = 1'b1;
				mem_req.write = 1'b1;
			end
			S_PUSH_HI: begin
				mem_req.valid = 1'b1;
				mem_req.write = 1'b1;
				mem_req.wdata = seq_data_r[31:16];
			end
			S_POP_HI, S_POP_LO: begin
				mem_req.valid = 1'b1;
				mem_req.addr  = {6'h00, stack_top_pointer_r - 16'h0001};
			end
			default: mem_req.valid = 1'b0;
		endcase
	end
	assign seq_busy = (seq_r != S_IDLE);

	// ==========================================================
	// Saved-return register; the long call, the long return and APB writes touch it.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			saved_return_pointer_r <= 22'h000000;
			return_addr            <= 22'h000000;
			return_valid           <= 1'b0;
		end else begin
			return_valid <= 1'b0;
			if (seq_r == S_IDLE && op == OP_LCALL) begin
				saved_return_pointer_r <= call_target;
			end else if (seq_r == S_IDLE && op == OP_LRET) begin
				return_addr  <= saved_return_pointer_r;
				return_valid <= 1'b1;
			end else if (seq_r == S_POP_LO && mem_ack && seq_is_ret_r) begin
				saved_return_pointer_r <= {pop_hi_r[5:0], mem_rdata};
			end else if (apb_wr && paddr == OFF_SAVED_RET) begin
				saved_return_pointer_r <= pwdata[21:0];
			end
		end
	end

	// ==========================================================
	// Instruction pointer follows the second decode stage.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			instr_pointer_r <= INSTR_PTR_RST;
		end else if (decode2_adv) begin
			instr_pointer_r <= decode2_addr;
		end
	end
	assign instr_pointer = instr_pointer_r;

	// ==========================================================
	// Status registers, each written at its own pipeline stage.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			exec_stage_status_r   <= 16'h0000;
			decode_stage_status_r <= DEC_ST_RST;
		end else begin
			if (exec_st_we) begin
				exec_stage_status_r <= exec_st_val;
			end else if (apb_wr && paddr == OFF_EXEC_ST) begin
				exec_stage_status_r <= pwdata[15:0];
			end
			if (dec_st_we) begin
				decode_stage_status_r <= dec_st_val;
			end else if (apb_wr && paddr == OFF_DEC_ST) begin
				decode_stage_status_r <= pwdata[15:0];
			end
		end
	end

	// ==========================================================
	// Interrupt flags; an acknowledge clears its flag, set wins.
	assign pend_mask = irq_pending_flags_r & irq_mask_bits_r;

	// Lowest numbered enabled pending flag is chosen.
	always_comb begin
		irq_pick = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (pend_mask[i]) begin
				irq_pick = 4'(i);
			end
		end
	end

	// Taken only between instructions, never flushing second decode.
	assign irq_take     = (|pend_mask) && decode2_adv;
	assign irq_take_num = irq_pick;

	// Clear mask from acknowledge and software write-one-to-clear.
	always_comb begin
		irq_clr = 16'h0000;
		if (irq_ack) begin
			irq_clr[irq_ack_num] = 1'b1;
		end
		if (apb_wr && paddr == OFF_IRQ_PEND) begin
			irq_clr = irq_clr | pwdata[31:16];
		end
	end

	// Flag and mask registers; software sets flags in the low half.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_pending_flags_r <= 16'h0000;
			irq_mask_bits_r     <= 16'h0000;
			debug_irq_mask_r    <= 16'h0000;
		end else begin
			if (apb_wr && paddr == OFF_IRQ_PEND) begin
				irq_pending_flags_r <= (irq_pending_flags_r & ~irq_clr)
					| irq_hw_set | pwdata[15:0];
			end else begin
				irq_pending_flags_r <= (irq_pending_flags_r & ~irq_clr)
					| irq_hw_set;
			end
			if (apb_wr && paddr == OFF_IRQ_MASK) begin
				irq_mask_bits_r <= pwdata[15:0];
			end
			if (apb_wr && paddr == OFF_DBG_MASK) begin
				debug_irq_mask_r <= pwdata[15:0];
			end
		end
	end

	// ==========================================================
	// Auxiliary pointers; one APB word per slot, always written whole.
	for (genvar g = 0; g < N_AUX; g++) begin : g_aux
		aux_pointer_slot u_slot (
			.clk_sys     (clk_sys),
			.rst         (rst),
			.wr_full     (apb_wr && paddr == OFF_AUX_BASE + 8'(4 * g)),
			.wr_low      (1'b0),
			.wr_low_keep (1'b1),
			.wdata       (pwdata),
			.value       (aux_val[g])
		);
	end

	// Operand views of the selected pointer.
	assign aux_pointer_regs = aux_val[aux_sel];
	assign aux_pointer_low  = aux_val[aux_sel][15:0];
	assign aux_prog_addr    = aux_val[aux_sel][21:0];

	// ==========================================================
	// Read data captured in the setup phase.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (apb_rd) begin
			if (paddr == OFF_DATA_PAGE) begin
				prdata <= {16'h0000, data_page_pointer_r};
			end else if (paddr == OFF_STACK_TOP) begin
				prdata <= {16'h0000, stack_top_pointer_r};
			end else if (paddr == OFF_INSTR_PTR) begin
				prdata <= {10'h000, instr_pointer_r};
			end else if (paddr == OFF_SAVED_RET) begin
				prdata <= {10'h000, saved_return_pointer_r};
			end else if (paddr == OFF_EXEC_ST) begin
				prdata <= {16'h0000, exec_stage_status_r};
			end else if (paddr == OFF_DEC_ST) begin
				prdata <= {16'h0000, decode_stage_status_r};
			end else if (paddr == OFF_IRQ_PEND) begin
				prdata <= {16'h0000, irq_pending_flags_r};
			end else if (paddr == OFF_IRQ_MASK) begin
				prdata <= {16'h0000, irq_mask_bits_r};
			end else if (paddr == OFF_DBG_MASK) begin
				prdata <= {16'h0000, debug_irq_mask_r};
			end else if (paddr == OFF_MODE) begin
				prdata <= mode_r;
			end else if (paddr >= OFF_AUX_BASE
					&& paddr < OFF_AUX_BASE + 8'(4 * N_AUX)) begin
				prdata <= aux_val[paddr[4:2]];
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

endmodule : cpu_pointer_registers

// ===== cpu_pointer_registers_checker.sv
`timescale 1ns/10ps

// ==========================================================
// Port checker for the pointer register block.
module cpu_pointer_registers_checker
	import ptr_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire ptr_op_e     op,
	input wire logic        seq_busy,
	input wire logic [31:0] push_data,
	input wire mem_req_s    mem_req,
	input wire logic        mem_ack,
	input wire logic [31:0] stack_addr,
	input wire logic [6:0]  page_offset,
	input wire logic [21:0] page_addr,
	input wire logic [31:0] aux_pointer_regs,
	input wire logic [15:0] aux_pointer_low,
	input wire logic        decode2_adv,
	input wire logic [21:0] decode2_addr,
	input wire logic [21:0] instr_pointer,
	input wire logic        irq_take,
	input wire logic        return_valid
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// A push is accepted, then a write lands on the stack.
	sequence s_push_go;
		op == OP_PUSH32 && !seq_busy;
	endsequence
	sequence s_wr_done;
		mem_req.valid && mem_req.write && mem_ack;
	endsequence

	// Stack and memory port.
	a_push_low_first: assert property (
		s_push_go |=> mem_req.valid && mem_req.write
		&& mem_req.wdata == $past(push_data[15:0])
		&& mem_req.addr == $past(stack_addr[21:0]))
		else $error("push did not start with the low half at the pointer");
	a_sp_steps_up: assert property (
		s_wr_done |=> stack_addr[15:0] == $past(stack_addr[15:0]) + 16'h1)
		else $error("stack pointer did not step up after a write");
	a_req_held: assert property (
		mem_req.valid && !mem_ack |=> $stable(mem_req))
		else $error("memory request changed before its acknowledge");
	a_stack_upper_zero: assert property (
		stack_addr[31:16] == 16'h0)
		else $error("stack address has upper bits set");
	// Addressing views.
	a_page_offset_in: assert property (
		page_addr[5:0] == page_offset[5:0])
		else $error("page address low bits differ from the offset");
	a_aux_low_view: assert property (
		aux_pointer_low == aux_pointer_regs[15:0])
		else $error("aux low view differs from the full pointer");
	// Pipeline side and APB answer.
	a_ip_follows: assert property (
		decode2_adv |=> instr_pointer == $past(decode2_addr))
		else $error("instruction pointer missed the decode address");
	a_irq_on_adv: assert property (
		irq_take |-> decode2_adv)
		else $error("interrupt taken outside an instruction boundary");
	a_ret_pulse: assert property (
		op == OP_LRET && !seq_busy |=> return_valid)
		else $error("long return gave no return address");
	a_apb_answer: assert property (pready && (!pslverr
		|| (psel && penable)))
		else $error("apb answer out of place");
endmodule : cpu_pointer_registers_checker

bind cpu_pointer_registers cpu_pointer_registers_checker chk (
	.clk_sys, .rst, .psel, .penable, .pready, .pslverr, .op, .seq_busy,
	.push_data, .mem_req, .mem_ack, .stack_addr, .page_offset,
	.page_addr, .aux_pointer_regs, .aux_pointer_low, .decode2_adv,
	.decode2_addr, .instr_pointer, .irq_take, .return_valid
);

// ===== stack_mem_model.sv
`timescale 1ns/10ps

// ==========================================================
// Word memory behind the stack port, with a settable answer delay.
module stack_mem_model
	import ptr_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire mem_req_s   mem_req,
	input  wire logic [3:0] dly,
	output logic            mem_ack,
	output logic [15:0]     mem_rdata
);
	logic [15:0] mem [0:65535];
	logic [3:0]  cnt_r = 4'h0;
	logic [15:0] last_r = 16'h0;
	logic        ack_r = 1'b0;

	// Acknowledge for one cycle after dly+1 waiting cycles.
	assign mem_ack = ack_r;
	always_ff @(posedge clk_sys) begin
		if (mem_req.valid && !ack_r) begin
			cnt_r <= cnt_r + 4'h1;
			ack_r <= (cnt_r >= dly);
		end else begin
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
		end
	end

	// Each request is one 16-bit word, so no pair needs aligning here.
	always_ff @(posedge clk_sys) begin
		if (mem_ack && mem_req.valid) begin
			if (mem_req.write) begin
				mem[mem_req.addr[15:0]] <= mem_req.wdata;
			end
			last_r <= mem_rdata;
		end
	end

	// Outside an acknowledge the data lines show a changed value.
	assign mem_rdata = mem_ack ? mem[mem_req.addr[15:0]] : ~last_r;
endmodule : stack_mem_model

// ===== cpu_pointer_registers_tb.sv
`timescale 1ns/10ps

// ==========================================================
// Self-checking bench for the pointer register block.
module cpu_pointer_registers_tb;
	import ptr_pkg::*;
	logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, push_data = 32'h0, prdata, q;
	logic [31:0] aux_pointer_regs;
	ptr_op_e     op = OP_NONE;
	logic [15:0] op_amount = 16'h0, exec_st_val = 16'h0, irq_hw_set = 16'h0;
	logic [15:0] aux_pointer_low, mem_rdata;
	logic [21:0] call_target = 22'h0, decode2_addr = 22'h0, page_addr;
	logic [21:0] aux_prog_addr, return_addr, instr_pointer, ra;
	logic        op_sub = 0, decode2_adv = 0, exec_st_we = 0, perr, rv, tk;
	logic        dec_st_we = 0, irq_ack = 0;
	logic [15:0] dec_st_val = 16'h0;
	logic [6:0]  page_offset = 7'h0;
	logic [2:0]  aux_sel = 3'h0;
	logic [3:0]  irq_take_num, dly = 4'h0, irq_ack_num = 4'h0;
	logic        pready, pslverr, mem_ack, seq_busy, return_valid, irq_take;
	mem_req_s    mem_req;
	logic [31:0] stack_addr;
	int          err_total = 0, total_checks = 0, cyc = 0;

	cpu_pointer_registers uut (.clk_sys, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .op, .op_amount,
		.op_sub, .call_target, .push_data, .decode2_adv, .decode2_addr,
		.exec_st_we, .exec_st_val, .dec_st_we, .dec_st_val,
		.irq_hw_set, .irq_ack, .irq_ack_num, .page_offset,
		.page_addr, .aux_sel, .aux_pointer_regs, .aux_pointer_low,
		.aux_prog_addr, .mem_req, .mem_ack, .mem_rdata, .seq_busy,
		.return_addr, .return_valid, .stack_addr, .instr_pointer,
		.irq_take, .irq_take_num);
	stack_mem_model mdl (.clk_sys, .mem_req, .dly, .mem_ack, .mem_rdata);

	// Free-running clock and a cycle ceiling against hangs.
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	// ======================================================
	// Shared helpers.
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer: setup, then access until pready.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q    = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd

	// Issue one sequencer operation and wait for it to finish.
	task automatic run_op(input ptr_op_e o);
		@(posedge clk_sys);
		op <= o;
		@(posedge clk_sys);
		op <= OP_NONE;
		@(posedge clk_sys);
		rv = return_valid;
		ra = return_addr;
		while (seq_busy !== 1'b0) @(posedge clk_sys);
	endtask : run_op

	// Pulse the decode advance and sample the interrupt decision.
	task automatic adv(input logic [21:0] a);
		@(posedge clk_sys);
		decode2_adv  <= 1'b1;
		decode2_addr <= a;
		@(posedge clk_sys);
		tk = irq_take;
		decode2_adv <= 1'b0;
		@(posedge clk_sys);
		chk("instr_pointer", a, instr_pointer);
	endtask : adv

	// ======================================================
	// Scenarios.
	task automatic t_reset;
		rd(OFF_STACK_TOP, 32'h0400);
		rd(OFF_INSTR_PTR, 32'h3fffc0);
		rd(OFF_DEC_ST, 32'h080b);
		rd(OFF_DATA_PAGE, 32'h0);
		chk("stack_addr", 32'h0400, stack_addr);
		apb(1'b1, OFF_INSTR_PTR, 32'h1);
		rd(OFF_INSTR_PTR, 32'h3fffc0);
		apb(1'b0, 8'h30, 32'h0);
		chk("pslverr", 32'h1, {31'h0, perr});
	endtask : t_reset

	task automatic t_page;
		logic [15:0] dp [3] = '{16'habcd, 16'hffff, 16'habcd};
		logic [6:0]  of [3] = '{7'h15, 7'h7f, 7'h15};
		logic [21:0] e;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFF_MODE, {31'h0, i == 2});
			apb(1'b1, OFF_DATA_PAGE, {16'h0, dp[i]});
			page_offset <= of[i];
			@(posedge clk_sys);
			e = (i == 2) ? {dp[i][15:1], of[i]} : {dp[i], of[i][5:0]};
			@(posedge clk_sys);
			chk("page_addr", e, page_addr);
		end
		apb(1'b1, OFF_MODE, 32'h0);
	endtask : t_page

	task automatic t_call;
		apb(1'b1, OFF_SAVED_RET, 32'h12345);
		apb(1'b1, OFF_STACK_TOP, 32'h0100);
		call_target <= 22'h2abcde;
		dly <= 4'h2;
		run_op(OP_LCALL);
		rd(OFF_SAVED_RET, 32'h2abcde);
		chk("lo word", 32'h2345, {16'h0, mdl.mem[16'h0100]});
		chk("hi word", 32'h0001, {16'h0, mdl.mem[16'h0101]});
		rd(OFF_STACK_TOP, 32'h0102);
		run_op(OP_LRET);
		chk("return_valid", 32'h1, {31'h0, rv});
		chk("return_addr", 32'h2abcde, {10'h0, ra});
		rd(OFF_SAVED_RET, 32'h12345);
		rd(OFF_STACK_TOP, 32'h0100);
	endtask : t_call

	task automatic t_stack;
		apb(1'b1, OFF_STACK_TOP, 32'hfffe);
		push_data <= 32'h12345678;
		dly <= 4'h3;
		run_op(OP_PUSH32);
		chk("push lo", 32'h5678, {16'h0, mdl.mem[16'hfffe]});
		chk("push hi", 32'h1234, {16'h0, mdl.mem[16'hffff]});
		chk("stack_addr", 32'h0, stack_addr);
		apb(1'b1, OFF_STACK_TOP, 32'h0002);
		op_amount <= 16'h4;
		op_sub <= 1'b1;
		run_op(OP_ADJ);
		rd(OFF_STACK_TOP, 32'hfffe);
		op_amount <= 16'h3;
		op_sub <= 1'b0;
		run_op(OP_ADJ);
		rd(OFF_STACK_TOP, 32'h0001);
		apb(1'b1, OFF_STACK_TOP, 32'h0083);
		push_data <= 32'hcafef00d;
		dly <= 4'h0;
		run_op(OP_PUSH32);
		chk("odd lo", 32'hf00d, {16'h0, mdl.mem[16'h0083]});
		chk("odd hi", 32'hcafe, {16'h0, mdl.mem[16'h0084]});
		rd(OFF_STACK_TOP, 32'h0085);
		rd(OFF_SAVED_RET, 32'h12345);
	endtask : t_stack

	task automatic t_core;
		apb(1'b1, OFF_AUX_BASE + 8'h14, 32'h89abcdef);
		aux_sel <= 3'h5;
		rd(OFF_AUX_BASE + 8'h14, 32'h89abcdef);
		chk("aux full", 32'h89abcdef, aux_pointer_regs);
		chk("aux low", 32'hcdef, {16'h0, aux_pointer_low});
		chk("aux prog", 32'h2bcdef, {10'h0, aux_prog_addr});
		exec_st_we  <= 1'b1;
		exec_st_val <= 16'h5a5a;
		@(posedge clk_sys);
		exec_st_we <= 1'b0;
		rd(OFF_EXEC_ST, 32'h5a5a);
		apb(1'b1, OFF_DEC_ST, 32'h1234);
		rd(OFF_DEC_ST, 32'h1234);
		dec_st_we  <= 1'b1;
		dec_st_val <= 16'h00c3;
		@(posedge clk_sys);
		dec_st_we <= 1'b0;
		rd(OFF_DEC_ST, 32'h00c3);
		irq_hw_set <= 16'h0008;
		@(posedge clk_sys);
		irq_hw_set <= 16'h0;
		rd(OFF_IRQ_PEND, 32'h0008);
		adv(22'h155aa);
		chk("irq masked", 32'h0, {31'h0, tk});
		apb(1'b1, OFF_IRQ_MASK, 32'h0008);
		adv(22'h0aa55);
		chk("irq_take", 32'h1, {31'h0, tk});
		chk("irq_take_num", 32'h3, {28'h0, irq_take_num});
		// A set and an acknowledge in one cycle: the set wins.
		irq_hw_set  <= 16'h0008;
		irq_ack     <= 1'b1;
		irq_ack_num <= 4'h3;
		@(posedge clk_sys);
		irq_hw_set <= 16'h0;
		irq_ack    <= 1'b0;
		rd(OFF_IRQ_PEND, 32'h0008);
		irq_ack <= 1'b1;
		@(posedge clk_sys);
		irq_ack <= 1'b0;
		rd(OFF_IRQ_PEND, 32'h0000);
	endtask : t_core

	// Reset for eight cycles, then run every scenario.
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_page();
		t_call();
		t_stack();
		t_core();
		close_out();
	end
endmodule : cpu_pointer_registers_tb
